// File: rtl/osc_power_pkg.sv
// Register map, field positions, timing and mode codes of the oscillator block.
`default_nettype none
package osc_power_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [ADDR_W-1:0] SYS_CLK_CTRL_ADDR = 3'h0;
    localparam logic [ADDR_W-1:0] HS_XTAL_CTRL_ADDR = 3'h1;
    localparam logic [ADDR_W-1:0] LS_XTAL_CTRL_ADDR = 3'h2;
    localparam logic [ADDR_W-1:0] POWER_STATUS_ADDR = 3'h3;

    // System clock control fields.
    localparam int DIV_W = 3;
    localparam int DIV_LSB = 5;
    localparam int HIGH_SRC_BIT = 3;
    localparam int SUB_SRC_BIT = 2;
    localparam int KEEP_HIGH_BIT = 1;
    localparam int KEEP_LOW_BIT = 0;
    localparam logic [DATA_W-1:0] SYS_CLK_CTRL_MASK = 8'hEF;
    localparam logic [DIV_W-1:0] DIV_SLOW = 3'h7;

    // Crystal control fields, shared by both crystal registers.
    localparam int XTAL_MODE_BIT = 2;
    localparam int XTAL_STABLE_BIT = 1;
    localparam int XTAL_EN_BIT = 0;
    localparam int XTAL_IMPL_W = 3;

    // Power status fields.
    localparam int PD_FLAG_BIT = 0;
    localparam int TO_FLAG_BIT = 1;
    localparam int SLOW_ACTIVE_BIT = 2;
    localparam int HALTED_BIT = 3;

    // Reset values.
    localparam logic [DATA_W-1:0] SYS_CLK_CTRL_RST = 8'h00;
    localparam logic LS_SPEEDUP_VALUE = 1'b1;

    // Divider chain and start-up timing.
    localparam int DIV_CNT_W = 6;
    localparam logic [DIV_CNT_W:0] DIV_ONE = 7'h01;
    localparam int CLK_PERIOD_NS = 20;
    localparam int HS_START_NS = 20000;
    localparam int LS_START_NS = 40000;
    localparam int STARTUP_CNT_W = 11;
    localparam logic [STARTUP_CNT_W-1:0] HS_START_CYCLES =
        STARTUP_CNT_W'((HS_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [STARTUP_CNT_W-1:0] LS_START_CYCLES =
        STARTUP_CNT_W'((LS_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [STARTUP_CNT_W-1:0] STARTUP_ONE = 11'h001;

    typedef enum logic [4:0] {
        MODE_RUN = 5'h01,
        MODE_SLEEP = 5'h02,
        MODE_SUB_ON = 5'h04,
        MODE_BOTH_ON = 5'h08,
        MODE_HIGH_ON = 5'h10
    } mode_t;
endpackage : osc_power_pkg
`default_nettype wire

// File: rtl/oscillator_and_power_mode_control.sv
// Crystal oscillator control, system clock selection and halt power modes.
`default_nettype none
// Summary of operation
// - Range bit picks crystal mode, resets low.
// - High crystal enable clears, then sets stable.
// - High crystal enable bit switches oscillator.
// - Low crystal speed-up bit reads one.
// - Low crystal enable clears, then sets stable.
// - Low crystal enable bit switches oscillator.
// - Upper five crystal register bits read zero.
// - Divider code seven selects slow sub clock.
// - Slow clock source chosen, must be stable.
// - Codes zero to six divide high clock.
// - Return to fast waits for stable source.
// - Halt with no keep bits enters sleep.
// - Halt keeping low clock stops high clock.
// - Halt keeping both clocks stops only CPU.
// - Halt keeping high clock stops sub clock.
// - Halt leaves memory, registers, ports unchanged.
// - Halt sets powerdown, clears timeout flag.
// - Halt clears watchdog, runs if enabled.
// - Sub source bit: internal or crystal.
// - High source bit: internal or crystal.
module oscillator_and_power_mode_control
    import osc_power_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [DATA_W-1:0] rdData,
    input wire logic haltReq,
    input wire logic wakeReq,
    input wire logic subClkTick,
    input wire logic fastInternalOscStable,
    input wire logic slowInternalOscStable,
    input wire logic watchdogEnable,
    input wire logic watchdogTimeout,
    input wire logic powerdownClear,
    output logic cpuRun,
    output logic sysClkTick,
    output logic highClockOn,
    output logic subClockOn,
    output logic slowInternalOscOn,
    output logic hsCrystalOscOn,
    output logic hsCrystalRangeHigh,
    output logic lsCrystalOscOn,
    output logic lsCrystalSpeedup,
    output logic watchdogClear,
    output logic watchdogRun
);
    localparam int CFG_W = DIV_W + 2;

    mode_t mode_reg, mode_next;
    logic [DATA_W-1:0] sysCtrl_reg;
    logic hsEn_reg, hsRange_reg, lsEn_reg;
    logic rangeOut_reg;
    logic pdFlag_reg, pdFlag_next;
    logic toFlag_reg, toFlag_next;
    logic wdtClear_reg;
    logic [DATA_W-1:0] rdData_reg;
    logic [CFG_W-1:0] cfgActive_reg;
    logic [DIV_CNT_W-1:0] divCnt_reg;
    logic [1:0] oscOn;
    logic [1:0] oscStable;

    // Register decode.
    wire logic wrSys = wrEn && (addr == SYS_CLK_CTRL_ADDR);
    wire logic wrHs = wrEn && (addr == HS_XTAL_CTRL_ADDR);
    wire logic wrLs = wrEn && (addr == LS_XTAL_CTRL_ADDR);

    // Requested configuration and the one currently driving the clock.
    wire logic [DIV_W-1:0] tgtDiv = sysCtrl_reg[DIV_LSB +: DIV_W];
    wire logic tgtHighSrc = sysCtrl_reg[HIGH_SRC_BIT];
    wire logic tgtSubSrc = sysCtrl_reg[SUB_SRC_BIT];
    wire logic [CFG_W-1:0] cfgTarget = {tgtDiv, tgtHighSrc, tgtSubSrc};
    wire logic [DIV_W-1:0] actDiv = cfgActive_reg[CFG_W-1 -: DIV_W];
    wire logic actHighSrc = cfgActive_reg[1];
    wire logic actSubSrc = cfgActive_reg[0];
    wire logic keepHigh = sysCtrl_reg[KEEP_HIGH_BIT];
    wire logic keepLow = sysCtrl_reg[KEEP_LOW_BIT];

    wire logic hsStable = oscStable[0];
    wire logic lsStable = oscStable[1];

    // Mode decode.
    wire logic modeRun = (mode_reg == MODE_RUN);
    wire logic modeSleep = (mode_reg == MODE_SLEEP);
    wire logic highKept = modeRun || (mode_reg == MODE_BOTH_ON) ||
                          (mode_reg == MODE_HIGH_ON);
    wire logic subKept = modeRun || (mode_reg == MODE_BOTH_ON) ||
                         (mode_reg == MODE_SUB_ON);
    wire logic haltEntry = haltReq && modeRun;

    // Oscillator enables follow the bits while their domain is kept alive.
    assign hsCrystalOscOn = hsEn_reg && highKept;
    assign lsCrystalOscOn = lsEn_reg && subKept;
    assign oscOn = {lsCrystalOscOn, hsCrystalOscOn};

    // Source selection and readiness.
    wire logic actHighReady = actHighSrc ? hsStable
                                         : fastInternalOscStable;
    wire logic actSubReady = actSubSrc ? lsStable
                                       : slowInternalOscStable;
    wire logic actSlow = (actDiv == DIV_SLOW);
    wire logic tgtSlow = (tgtDiv == DIV_SLOW);
    wire logic tgtReady = tgtSlow
        ? (tgtSubSrc ? lsStable : slowInternalOscStable)
        : (tgtHighSrc ? hsStable : fastInternalOscStable);
    wire logic actReady = actSlow ? actSubReady : actHighReady;

    // Divider chain: a tick every 2^code high clock cycles.
    wire logic [DIV_W-1:0] divShift = actSlow ? '0 : actDiv;
    wire logic [DIV_CNT_W-1:0] divMask =
        DIV_CNT_W'((DIV_ONE << divShift) - DIV_ONE);
    wire logic divWrap = ((divCnt_reg & divMask) == divMask);
    wire logic oldEdge = actSlow ? subClkTick : divWrap;

    // Changeover happens on a boundary of the old clock when the new
    // source is running; a dead old source cannot block the change.
    wire logic cfgSwitch = (cfgTarget != cfgActive_reg) && tgtReady &&
                           (oldEdge || !actReady);

    assign highClockOn = highKept && actHighReady;
    assign subClockOn = subKept && actSubReady;
    assign slowInternalOscOn = !modeSleep || watchdogEnable;
    assign cpuRun = modeRun;
    assign sysClkTick = cpuRun && (actSlow ? (subClkTick && actSubReady)
                                           : (highClockOn && divWrap));
    assign lsCrystalSpeedup = LS_SPEEDUP_VALUE;
    assign hsCrystalRangeHigh = rangeOut_reg;
    assign watchdogClear = wdtClear_reg;
    assign watchdogRun = watchdogEnable && !wdtClear_reg;
    assign rdData = rdData_reg;

    // Start-up counters for the two crystals.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gStartup
            localparam logic [STARTUP_CNT_W-1:0] TERM =
                (g == 0) ? HS_START_CYCLES : LS_START_CYCLES;
            logic [STARTUP_CNT_W-1:0] cnt_reg;
            logic stable_reg;
            wire logic atTerm = (cnt_reg == TERM);
            always_ff @(posedge mclk) begin
                if (!rstn || !oscOn[g]) begin
                    cnt_reg <= '0;
                    stable_reg <= 1'b0;
                end else begin
                    cnt_reg <= atTerm ? cnt_reg : cnt_reg + STARTUP_ONE;
                    stable_reg <= atTerm;
                end
            end
            assign oscStable[g] = stable_reg;
        end
    endgenerate

    // Halt mode selection from the keep bits.
    always_comb begin
        mode_next = mode_reg;
        unique case (1'b1)
            mode_reg[0]: begin
                if (haltReq) begin
                    unique case ({keepHigh, keepLow})
                        2'b00: mode_next = MODE_SLEEP;
                        2'b01: mode_next = MODE_SUB_ON;
                        2'b11: mode_next = MODE_BOTH_ON;
                        2'b10: mode_next = MODE_HIGH_ON;
                    endcase
                end
            end
            mode_reg[1], mode_reg[2], mode_reg[3], mode_reg[4]: begin
                if (wakeReq) begin
                    mode_next = MODE_RUN;
                end
            end
            default: mode_next = MODE_RUN;
        endcase
    end

    // Timeout event wins over the clear at halt; halt wins over clear.
    assign pdFlag_next = haltEntry ? 1'b1
                       : (powerdownClear ? 1'b0 : pdFlag_reg);
    assign toFlag_next = watchdogTimeout ? 1'b1
                       : (haltEntry ? 1'b0 : toFlag_reg);

    // Read multiplexer; unmapped addresses read zero.
    wire logic [DATA_W-1:0] rdSys = sysCtrl_reg & SYS_CLK_CTRL_MASK;
    wire logic [DATA_W-1:0] rdHs = DATA_W'({hsRange_reg, hsStable,
                                            hsEn_reg});
    wire logic [DATA_W-1:0] rdLs = DATA_W'({lsCrystalSpeedup, lsStable,
                                            lsEn_reg});
    wire logic [DATA_W-1:0] rdStat = DATA_W'({!modeRun, actSlow,
                                              toFlag_reg, pdFlag_reg});
    wire logic [DATA_W-1:0] rdMux =
        (addr == SYS_CLK_CTRL_ADDR) ? rdSys :
        (addr == HS_XTAL_CTRL_ADDR) ? rdHs :
        (addr == LS_XTAL_CTRL_ADDR) ? rdLs :
        (addr == POWER_STATUS_ADDR) ? rdStat : '0;

    // Control registers keep their contents through every halt mode.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sysCtrl_reg <= SYS_CLK_CTRL_RST;
            hsEn_reg <= 1'b0;
            hsRange_reg <= 1'b0;
            lsEn_reg <= 1'b0;
        end else begin
            if (wrSys) begin
                sysCtrl_reg <= wrData & SYS_CLK_CTRL_MASK;
            end
            if (wrHs) begin
                hsEn_reg <= wrData[XTAL_EN_BIT];
                hsRange_reg <= wrData[XTAL_MODE_BIT];
            end
            if (wrLs) begin
                lsEn_reg <= wrData[XTAL_EN_BIT];
            end
        end
    end

    // The crystal only sees the range while it is off.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rangeOut_reg <= 1'b0;
        end else if (!hsCrystalOscOn) begin
            rangeOut_reg <= hsRange_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode_reg <= MODE_RUN;
            pdFlag_reg <= 1'b0;
            toFlag_reg <= 1'b0;
            wdtClear_reg <= 1'b0;
            rdData_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            pdFlag_reg <= pdFlag_next;
            toFlag_reg <= toFlag_next;
            wdtClear_reg <= haltEntry;
            rdData_reg <= rdEn ? rdMux : '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cfgActive_reg <= '0;
            divCnt_reg <= '0;
        end else begin
            if (cfgSwitch) begin
                cfgActive_reg <= cfgTarget;
            end
            divCnt_reg <= highClockOn ? divCnt_reg + DIV_ONE[DIV_CNT_W-1:0]
                                      : divCnt_reg;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_range_frozen: assert property (
        hsCrystalOscOn && $past(hsCrystalOscOn) |-> $stable(hsCrystalRangeHigh)
    ) else $error("Crystal range changed while running.");

    a_hs_stable_clear: assert property (
        $rose(hsCrystalOscOn) |-> !hsStable [*8]
    ) else $error("High crystal stable not cleared at enable.");

    a_hs_off_unstable: assert property (
        !hsCrystalOscOn |=> !hsStable
    ) else $error("High crystal stable while off.");

    a_ls_stable_clear: assert property (
        $rose(lsCrystalOscOn) |-> !lsStable [*8]
    ) else $error("Low crystal stable not cleared at enable.");

    a_ls_speedup_read: assert property (
        rdEn && addr == LS_XTAL_CTRL_ADDR |=> rdData[XTAL_MODE_BIT]
    ) else $error("Speed-up bit did not read one.");

    a_xtal_upper_zero: assert property (
        rdEn && (addr == HS_XTAL_CTRL_ADDR || addr == LS_XTAL_CTRL_ADDR)
        |=> rdData[DATA_W-1:XTAL_IMPL_W] == '0
    ) else $error("Unimplemented crystal bits not zero.");

    a_switch_ready: assert property (
        cfgActive_reg != $past(cfgActive_reg) |-> $past(tgtReady)
    ) else $error("Clock switched to an unstable source.");

    a_sleep_clocks: assert property (
        modeSleep |-> !highClockOn && !subClockOn && !sysClkTick
    ) else $error("Clock running in sleep.");

    a_idle_sub: assert property (
        mode_reg == MODE_SUB_ON |-> !highClockOn && !cpuRun && !sysClkTick
    ) else $error("High clock or CPU running in sub idle.");

    a_halt_flags: assert property (
        haltEntry && !watchdogTimeout |=> pdFlag_reg && !toFlag_reg
    ) else $error("Powerdown or timeout flag wrong after halt.");

    a_wdt_clear: assert property (
        haltEntry |=> watchdogClear ##1 !watchdogClear
    ) else $error("Watchdog clear pulse wrong at halt.");

    a_ls_off_unstable: assert property (
        !lsCrystalOscOn |=> !lsStable
    ) else $error("Low crystal stable while off.");

    a_slow_tick_source: assert property (
        actSlow && sysClkTick |-> subClkTick
    ) else $error("Slow system tick without a sub clock tick.");

    a_fast_tick_space: assert property (
        !actSlow && actDiv != '0 && sysClkTick
        |=> !sysClkTick || $changed(cfgActive_reg)
    ) else $error("Divided system ticks came back to back.");

    a_slow_src_ready: assert property (
        $rose(actSlow)
        |-> (actSubSrc ? $past(lsStable) : $past(slowInternalOscStable))
    ) else $error("Slow mode entered on an unstable sub source.");

    a_fast_src_ready: assert property (
        $fell(actSlow)
        |-> (actHighSrc ? $past(hsStable) : $past(fastInternalOscStable))
    ) else $error("Fast mode entered on an unstable high source.");

    a_hs_src_gate: assert property (
        actHighSrc && !hsStable |-> !highClockOn
    ) else $error("High clock on from an unstable crystal.");

    a_idle_both: assert property (
        mode_reg == MODE_BOTH_ON |-> !cpuRun && !sysClkTick &&
        highClockOn == actHighReady && subClockOn == actSubReady
    ) else $error("Clocks or CPU wrong with both clocks kept.");

    a_idle_high: assert property (
        mode_reg == MODE_HIGH_ON
        |-> !cpuRun && !subClockOn && !lsCrystalOscOn
    ) else $error("Sub clock or CPU running in high idle.");

    a_idle_sub_xtal: assert property (
        mode_reg == MODE_SUB_ON |-> !hsCrystalOscOn
    ) else $error("High crystal running in sub idle.");

    a_sleep_xtals: assert property (
        modeSleep |-> !hsCrystalOscOn && !lsCrystalOscOn &&
        slowInternalOscOn == watchdogEnable
    ) else $error("Oscillator running in sleep.");

    a_halt_regs_kept: assert property (
        haltEntry && !wrEn
        |=> $stable(sysCtrl_reg) && $stable(hsEn_reg) && $stable(lsEn_reg)
    ) else $error("Control register changed at halt entry.");

    a_hs_stable_age: assert property (
        hsStable |-> $past(hsCrystalOscOn, 8)
    ) else $error("High crystal stable too soon after enable.");

    a_switch_boundary: assert property (
        $changed(cfgActive_reg) && $past(actSlow && actSubReady)
        |-> $past(subClkTick)
    ) else $error("Clock left slow mode off a sub clock boundary.");

    a_pd_hold: assert property (
        pdFlag_reg && !powerdownClear |=> pdFlag_reg
    ) else $error("Powerdown flag lost without a clear.");

    a_wdt_run_idle: assert property (
        !modeRun && !watchdogClear |-> watchdogRun == watchdogEnable
    ) else $error("Watchdog run wrong while halted.");

    c_sleep_entry: cover property (haltEntry && !keepHigh && !keepLow);
    c_slow_switch: cover property ($rose(actSlow));
    c_hs_stable: cover property ($rose(hsStable));
    c_wake: cover property (!modeRun ##1 modeRun);
    c_hs_switch: cover property ($fell(actSlow) && actHighSrc);
endmodule : oscillator_and_power_mode_control
`default_nettype wire

// File: test/oscillator_and_power_mode_control_test.sv
// Register-level testbench of the oscillator and power mode block.
`default_nettype none
module oscillator_and_power_mode_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import osc_power_pkg::*;

    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wrData = '0;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic haltReq = 1'b0;
    logic wakeReq = 1'b0;
    logic subClkTick = 1'b0;
    logic [2:0] subCnt = 3'h0;
    logic fastInternalOscStable = 1'b1;
    logic slowInternalOscStable = 1'b1;
    logic watchdogEnable = 1'b0;
    logic watchdogTimeout = 1'b0;
    logic powerdownClear = 1'b0;
    wire logic [DATA_W-1:0] rdData;
    wire logic cpuRun, sysClkTick, highClockOn, subClockOn, slowInternalOscOn;
    wire logic hsCrystalOscOn, hsCrystalRangeHigh, lsCrystalOscOn;
    wire logic lsCrystalSpeedup, watchdogClear, watchdogRun;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n;
    localparam int PULSE_TIMEOUT = 0;
    localparam int PULSE_HALT = 1;
    localparam int PULSE_WAKE = 2;
    localparam int PULSE_PD_CLEAR = 3;

    oscillator_and_power_mode_control u_dut (.mclk(mclk), .rstn(rstn),
        .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
        .rdData(rdData), .haltReq(haltReq), .wakeReq(wakeReq),
        .subClkTick(subClkTick),
        .fastInternalOscStable(fastInternalOscStable),
        .slowInternalOscStable(slowInternalOscStable),
        .watchdogEnable(watchdogEnable), .watchdogTimeout(watchdogTimeout),
        .powerdownClear(powerdownClear), .cpuRun(cpuRun),
        .sysClkTick(sysClkTick), .highClockOn(highClockOn),
        .subClockOn(subClockOn), .slowInternalOscOn(slowInternalOscOn),
        .hsCrystalOscOn(hsCrystalOscOn),
        .hsCrystalRangeHigh(hsCrystalRangeHigh),
        .lsCrystalOscOn(lsCrystalOscOn), .lsCrystalSpeedup(lsCrystalSpeedup),
        .watchdogClear(watchdogClear), .watchdogRun(watchdogRun));

    initial begin
        forever #10 mclk = ~mclk;
    end

    // The sub clock is stood in for by one tick every eight cycles.
    always @(posedge mclk) begin
        subCnt <= subCnt + 3'h1;
        subClkTick <= (subCnt == 3'h7);
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge mclk);
        wrEn <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge mclk);
        rdEn <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask : rd

    task automatic pulse(input int sel);
        @(posedge mclk);
        case (sel)
            PULSE_TIMEOUT: watchdogTimeout <= 1'b1;
            PULSE_HALT: haltReq <= 1'b1;
            PULSE_WAKE: wakeReq <= 1'b1;
            default: powerdownClear <= 1'b1;
        endcase
        @(posedge mclk);
        watchdogTimeout <= 1'b0;
        haltReq <= 1'b0;
        wakeReq <= 1'b0;
        powerdownClear <= 1'b0;
        #1;
    endtask : pulse

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge mclk);
    endtask : wait_cyc

    task automatic count_ticks(output int cnt);
        cnt = 0;
        repeat (128) begin
            @(posedge mclk);
            #1;
            if (sysClkTick === 1'b1) cnt++;
        end
    endtask : count_ticks

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        wait_cyc(20000);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        wait_cyc(5);
        rstn <= 1'b1;
        rd(SYS_CLK_CTRL_ADDR, 8'h00);
        rd(HS_XTAL_CTRL_ADDR, 8'h00);
        rd(LS_XTAL_CTRL_ADDR, 8'h04);
        chk(lsCrystalSpeedup, 1'b1);
        // Range first, then enable; stable must start low and rise later.
        wr(HS_XTAL_CTRL_ADDR, 8'hFC);
        rd(HS_XTAL_CTRL_ADDR, 8'h04);
        chk(hsCrystalRangeHigh, 1'b1);
        wr(HS_XTAL_CTRL_ADDR, 8'h05);
        #1;
        chk(hsCrystalOscOn, 1'b1);
        rd(HS_XTAL_CTRL_ADDR, 8'h05);
        wait_cyc(int'(HS_START_CYCLES) + 2);
        rd(HS_XTAL_CTRL_ADDR, 8'h07);
        wr(HS_XTAL_CTRL_ADDR, 8'h01);
        #1;
        chk(hsCrystalRangeHigh, 1'b1);
        wr(HS_XTAL_CTRL_ADDR, 8'h00);
        #1;
        chk(hsCrystalOscOn, 1'b0);
        rd(HS_XTAL_CTRL_ADDR, 8'h00);
        chk(hsCrystalRangeHigh, 1'b0);
        wr(LS_XTAL_CTRL_ADDR, 8'hFF);
        #1;
        chk(lsCrystalOscOn, 1'b1);
        rd(LS_XTAL_CTRL_ADDR, 8'h05);
        wait_cyc(int'(LS_START_CYCLES) + 2);
        rd(LS_XTAL_CTRL_ADDR, 8'h07);
        wr(LS_XTAL_CTRL_ADDR, 8'h00);
        rd(LS_XTAL_CTRL_ADDR, 8'h04);
        wr(SYS_CLK_CTRL_ADDR, 8'hFF);
        rd(SYS_CLK_CTRL_ADDR, 8'hEF);
        rd(3'h5, 8'h00);
        wr(POWER_STATUS_ADDR, 8'hFF);
        rd(POWER_STATUS_ADDR, 8'h00);
        // Divider codes, then the slow sub clock, then back to full speed.
        for (int d = 0; d < 8; d++) begin
            wr(SYS_CLK_CTRL_ADDR, {d[2:0], 5'h00});
            wait_cyc(140);
            count_ticks(n);
            chk(8'(n), (d == 7) ? 8'h10 : 8'(128 >> d));
        end
        rd(POWER_STATUS_ADDR, 8'h04);
        // Going back to fast on a crystal that is still off has to wait.
        wr(SYS_CLK_CTRL_ADDR, 8'h08);
        wait_cyc(20);
        rd(POWER_STATUS_ADDR, 8'h04);
        wr(HS_XTAL_CTRL_ADDR, 8'h01);
        wait_cyc(int'(HS_START_CYCLES) + 20);
        rd(POWER_STATUS_ADDR, 8'h00);
        count_ticks(n);
        chk(8'(n), 8'h80);
        wr(SYS_CLK_CTRL_ADDR, 8'h00);
        wait_cyc(20);
        count_ticks(n);
        chk(8'(n), 8'h80);
        wr(HS_XTAL_CTRL_ADDR, 8'h00);
        // Every combination of the two keep bits, with flags primed.
        for (int k = 0; k < 4; k++) begin
            wr(SYS_CLK_CTRL_ADDR, {6'h00, k[1:0]});
            watchdogEnable <= (k != 0);
            pulse(PULSE_TIMEOUT);
            rd(POWER_STATUS_ADDR, 8'h02);
            pulse(PULSE_HALT);
            chk(cpuRun, 1'b0);
            chk(watchdogClear, 1'b1);
            chk(watchdogRun, 1'b0);
            chk(highClockOn, k[1]);
            chk(subClockOn, k[0]);
            chk(slowInternalOscOn, (k != 0));
            wait_cyc(1);
            #1;
            chk(watchdogRun, (k != 0));
            rd(POWER_STATUS_ADDR, 8'h09);
            rd(SYS_CLK_CTRL_ADDR, {6'h00, k[1:0]});
            pulse(PULSE_WAKE);
            chk(cpuRun, 1'b1);
            pulse(PULSE_PD_CLEAR);
            rd(POWER_STATUS_ADDR, 8'h00);
        end
        give_verdict();
    end
endmodule : oscillator_and_power_mode_control_test
`default_nettype wire
